// ---- hdl/wpm_pkg.sv ----
// Package for the write-path mode register block: field positions, codes, masks, state types.
// Assumes one clock domain; command/address pins sampled synchronously.
package wpm_pkg;
   localparam int MR_W = 22;
   localparam logic [2:0] SEL_MR1 = 3'h1;
   localparam logic [2:0] SEL_MR2 = 3'h2;
   localparam logic [2:0] SEL_UNUSED = 3'h7;
   localparam int SEL_LSB = 18;
   localparam int MR1_OUT_OFF = 12;
   localparam int MR1_XTS = 11;
   localparam int MR1_LEVEL = 7;
   localparam int MR1_AL_LSB = 3;
   localparam int MR2_CRC = 12;
   localparam int MR2_RTTWR_LSB = 9;
   localparam int MR2_SRT_LSB = 6;
   localparam int MR2_CWL_LSB = 3;
   localparam logic [21:0] MR2_RSVD_MASK = 22'h22_2107;
   localparam logic [21:0] MR_RESET = 22'h00_0000;
   localparam logic [2:0] RTTWR_OFF = 3'h0;
   localparam logic [2:0] RTTWR_DIV2 = 3'h1;
   localparam logic [2:0] RTTWR_DIV1 = 3'h2;
   localparam logic [2:0] RTTWR_HIZ = 3'h3;
   localparam logic [2:0] RTTWR_DIV3 = 3'h4;
   localparam logic [1:0] AL_RSVD = 2'h3;
   localparam logic [1:0] AL_ONE = 2'h1;
   localparam logic [1:0] AL_TWO = 2'h2;
   typedef enum logic [2:0] {
      WPM_TERM_OFF = 3'b001,
      WPM_TERM_NOM = 3'b010,
      WPM_TERM_WR = 3'b100
   } wpm_term_e;
   typedef struct packed {
      logic [21:0] mr1;
      logic [21:0] mr2;
      logic [5:0] wl;
      wpm_term_e term;
      logic rsvd_err;
   } wpm_state_s;
endpackage : wpm_pkg

// ---- hdl/wpm_mode_regs.sv ----
// Decodes MODE REGISTER SET for registers 1 and 2 and derives write-path controls.
// Assumes controller pins are synchronous to MCLK; read latency is an input.
`timescale 1ns/1ns
module wpm_mode_regs (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic CMD_VALID,
   input wire logic RAS_N,
   input wire logic CAS_N,
   input wire logic WE_N,
   input wire logic [1:0] BG,
   input wire logic [1:0] BA,
   input wire logic A17,
   input wire logic [13:0] A,
   input wire logic WRITE_ACTIVE,
   input wire logic TWO_CLK_PREAMBLE,
   input wire logic [4:0] READ_LATENCY,
   input wire logic [2:0] PARITY_DELAY,
   output logic OUTPUT_DISABLE,
   output logic EXTRA_TERMINATION_STROBE,
   output logic WRITE_BYTE_MASK_ALLOWED,
   output logic BUS_INVERSION_ALLOWED,
   output logic WRITE_CRC_EN,
   output logic [2:0] WRITE_TIME_TERMINATION,
   output logic [1:0] SELFREFRESH_TEMP_RANGE,
   output logic AUTOMATIC_RANGE_SWITCHING,
   output logic [4:0] COLUMN_WRITE_DELAY,
   output logic CWL_CODE_INVALID,
   output logic WRITE_LEVELING,
   output logic [2:0] TERM_SELECT,
   output logic [5:0] TOTAL_WRITE_DELAY,
   output logic RESERVED_ERROR
);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] cwl_of(input logic [2:0] code);
      logic [4:0] t;
      t = 5'h09;
      case (code)
         3'd0: t = 5'h09;
         3'd1: t = 5'h0a;
         3'd2: t = 5'h0b;
         3'd3: t = 5'h0c;
         3'd4: t = 5'h0e;
         3'd5: t = 5'h10;
         3'd6: t = 5'h12;
         default: t = 5'h14;
      endcase
      return t;
   endfunction : cwl_of

   function automatic logic [4:0] al_of(input logic [1:0] code, input logic [4:0] rl);
      logic [4:0] t;
      t = 5'h00;
      if (code == wpm_pkg::AL_ONE) begin
         t = rl - 5'h01;
      end else if (code == wpm_pkg::AL_TWO) begin
         t = rl - 5'h02;
      end
      return t;
   endfunction : al_of

   ////////////////////////////////////////////////////////////////////////////////
   wpm_pkg::wpm_state_s st_r;
   wpm_pkg::wpm_state_s st_nxt;
   logic mrs;
   logic [21:0] word;
   logic [2:0] sel;
   logic [2:0] cwl_code;
   logic [1:0] al_code;

   assign mrs = CMD_VALID && !RAS_N && !CAS_N && !WE_N;
   assign word = {BG, BA, A17, 3'b000, A};
   assign sel = word[wpm_pkg::SEL_LSB +: 3];
   assign cwl_code = st_r.mr2[wpm_pkg::MR2_CWL_LSB +: 3];
   assign al_code = st_r.mr1[wpm_pkg::MR1_AL_LSB +: 2];

   always_comb begin
      st_nxt = st_r;
      // Unused select code is dropped so no register is corrupted
      if (mrs && sel == wpm_pkg::SEL_MR1) begin
         st_nxt.mr1 = word;
      end
      if (mrs && sel == wpm_pkg::SEL_MR2) begin
         st_nxt.mr2 = word;
         st_nxt.rsvd_err = |(word & wpm_pkg::MR2_RSVD_MASK);
      end
      // Latency sum uses the held fields; reserved added-delay code counts as zero
      st_nxt.wl = {1'b0, (al_code == wpm_pkg::AL_RSVD) ? 5'h00 : al_of(al_code, READ_LATENCY)}
         + {1'b0, cwl_of(cwl_code)} + {3'b000, PARITY_DELAY};
      // Termination chosen per write on its own, no command needed
      if (st_r.mr1[wpm_pkg::MR1_LEVEL]) begin
         st_nxt.term = wpm_pkg::WPM_TERM_NOM;
      end else if (WRITE_ACTIVE
                   && st_r.mr2[wpm_pkg::MR2_RTTWR_LSB +: 3] != wpm_pkg::RTTWR_OFF) begin
         st_nxt.term = wpm_pkg::WPM_TERM_WR;
      end else begin
         st_nxt.term = wpm_pkg::WPM_TERM_NOM;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         st_r <= '{mr1: wpm_pkg::MR_RESET, mr2: wpm_pkg::MR_RESET, wl: 6'h00,
                   term: wpm_pkg::WPM_TERM_OFF, rsvd_err: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign OUTPUT_DISABLE = st_r.mr1[wpm_pkg::MR1_OUT_OFF];
   // x16 part: enable drives termination on the strobe pins instead
   assign EXTRA_TERMINATION_STROBE = st_r.mr1[wpm_pkg::MR1_XTS];
   assign WRITE_BYTE_MASK_ALLOWED = !st_r.mr1[wpm_pkg::MR1_XTS];
   assign BUS_INVERSION_ALLOWED = !st_r.mr1[wpm_pkg::MR1_XTS];
   assign WRITE_CRC_EN = st_r.mr2[wpm_pkg::MR2_CRC];
   assign WRITE_TIME_TERMINATION = st_r.mr1[wpm_pkg::MR1_LEVEL] ? wpm_pkg::RTTWR_OFF
      : st_r.mr2[wpm_pkg::MR2_RTTWR_LSB +: 3];
   assign SELFREFRESH_TEMP_RANGE = st_r.mr2[wpm_pkg::MR2_SRT_LSB +: 2];
   assign AUTOMATIC_RANGE_SWITCHING = &st_r.mr2[wpm_pkg::MR2_SRT_LSB +: 2];
   assign COLUMN_WRITE_DELAY = cwl_of(cwl_code);
   assign CWL_CODE_INVALID = TWO_CLK_PREAMBLE && !cwl_code[2];
   assign WRITE_LEVELING = st_r.mr1[wpm_pkg::MR1_LEVEL];
   assign TERM_SELECT = st_r.term;
   assign TOTAL_WRITE_DELAY = st_r.wl;
   assign RESERVED_ERROR = st_r.rsvd_err;

   ////////////////////////////////////////////////////////////////////////////////
   sequence s_mr2_write;
      mrs && sel == wpm_pkg::SEL_MR2;
   endsequence

   sequence s_mr1_write;
      mrs && sel == wpm_pkg::SEL_MR1;
   endsequence

   a_mr2_load_field: assert property (@(posedge MCLK) disable iff (!RST_N)
      s_mr2_write |=> WRITE_CRC_EN == $past(A[12]))
      else $error("crc enable not loaded");
   a_mr2_hold_value: assert property (@(posedge MCLK) disable iff (!RST_N)
      !(mrs && sel == wpm_pkg::SEL_MR2) |=> $stable(st_r.mr2))
      else $error("register two changed without command");
   a_unused_sel_drop: assert property (@(posedge MCLK) disable iff (!RST_N)
      mrs && sel == wpm_pkg::SEL_UNUSED |=> $stable(st_r.mr1) && $stable(st_r.mr2))
      else $error("unused select changed state");
   a_strobe_term_mask: assert property (@(posedge MCLK) disable iff (!RST_N)
      EXTRA_TERMINATION_STROBE |-> !WRITE_BYTE_MASK_ALLOWED && !BUS_INVERSION_ALLOWED)
      else $error("mask allowed with strobe termination");
   a_level_nom_term: assert property (@(posedge MCLK) disable iff (!RST_N)
      WRITE_LEVELING ##1 WRITE_LEVELING |-> TERM_SELECT == wpm_pkg::WPM_TERM_NOM)
      else $error("write termination during leveling");
   a_dyn_term_auto: assert property (@(posedge MCLK) disable iff (!RST_N)
      WRITE_ACTIVE && !WRITE_LEVELING && WRITE_TIME_TERMINATION != wpm_pkg::RTTWR_OFF
      && !mrs |=> TERM_SELECT == wpm_pkg::WPM_TERM_WR)
      else $error("write termination not applied");
   a_out_disable_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
      OUTPUT_DISABLE && !(mrs && sel == wpm_pkg::SEL_MR1) |=> OUTPUT_DISABLE)
      else $error("output disable dropped");
   a_cwl_range: assert property (@(posedge MCLK) disable iff (!RST_N)
      COLUMN_WRITE_DELAY >= 5'h09 && COLUMN_WRITE_DELAY <= 5'h14)
      else $error("column write delay out of range");
   // Reset release reloads the sum once, so that edge is left out
   a_wl_sum_track: assert property (@(posedge MCLK) disable iff (!RST_N)
      $stable(st_r.mr1) && $stable(st_r.mr2) && $stable(READ_LATENCY)
      && $stable(PARITY_DELAY) && $past(RST_N) |=> $stable(TOTAL_WRITE_DELAY))
      else $error("write delay moved without cause");
   a_mr1_load_bits: assert property (@(posedge MCLK) disable iff (!RST_N)
      s_mr1_write |=> OUTPUT_DISABLE == $past(A[12]) && WRITE_LEVELING == $past(A[7])
      && EXTRA_TERMINATION_STROBE == $past(A[11]))
      else $error("register one bits not loaded");
   a_wtt_load_code: assert property (@(posedge MCLK) disable iff (!RST_N)
      s_mr2_write ##1 !WRITE_LEVELING |-> WRITE_TIME_TERMINATION == $past(A[11:9]))
      else $error("write termination code not loaded");
   a_srt_load_code: assert property (@(posedge MCLK) disable iff (!RST_N)
      s_mr2_write |=> SELFREFRESH_TEMP_RANGE == $past(A[7:6])
      && AUTOMATIC_RANGE_SWITCHING == (&$past(A[7:6])))
      else $error("self refresh range not loaded");
   // Flag is checked against the pins, not against the stored word
   a_rsvd_flag_set: assert property (@(posedge MCLK) disable iff (!RST_N)
      s_mr2_write |=> RESERVED_ERROR
      == $past(BG[1] || A17 || A[13] || A[8] || A[2] || A[1] || A[0]))
      else $error("reserved bit flag wrong");
   a_mask_free_on: assert property (@(posedge MCLK) disable iff (!RST_N)
      !EXTRA_TERMINATION_STROBE |-> WRITE_BYTE_MASK_ALLOWED && BUS_INVERSION_ALLOWED)
      else $error("mask blocked without strobe termination");
   a_cwl_code_check: assert property (@(posedge MCLK) disable iff (!RST_N)
      CWL_CODE_INVALID == (TWO_CLK_PREAMBLE && COLUMN_WRITE_DELAY < 5'h0e))
      else $error("invalid latency code flag wrong");
   a_level_wtt_off: assert property (@(posedge MCLK) disable iff (!RST_N)
      WRITE_LEVELING |-> WRITE_TIME_TERMINATION == wpm_pkg::RTTWR_OFF)
      else $error("write termination shown during leveling");
   a_term_idle_nom: assert property (@(posedge MCLK) disable iff (!RST_N)
      !WRITE_ACTIVE |=> TERM_SELECT == wpm_pkg::WPM_TERM_NOM)
      else $error("write termination without a write");
   a_term_one_hot: assert property (@(posedge MCLK) disable iff (!RST_N)
      $onehot(TERM_SELECT))
      else $error("termination select not one hot");
   a_cwl_hold_mr1: assert property (@(posedge MCLK) disable iff (!RST_N)
      s_mr1_write |=> $stable(COLUMN_WRITE_DELAY))
      else $error("register one write moved write latency");
endmodule : wpm_mode_regs

// ---- tb/wpm_ctl_model.sv ----
// Controller model: issues mode register set commands on the pins.
// Assumes the device samples the pins on the rising clock edge.
`timescale 1ns/1ns
module wpm_ctl_model (
   input wire logic clk,
   output logic cmd_valid,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [1:0] bg,
   output logic [1:0] ba,
   output logic a17,
   output logic [13:0] a
);
   ////////////////////////////////////////////////////////////////
   initial begin
      {cmd_valid, ras_n, cas_n, we_n} = 4'h7;
      {bg, ba, a17, a} = 19'h0_0000;
   end
   // Released pins show the inverse, so a stale word never looks valid
   task automatic mrs(input logic [21:0] w);
      @(posedge clk);
      {cmd_valid, ras_n, cas_n, we_n} <= 4'h8;
      {bg, ba, a17, a} <= {w[21:17], w[13:0]};
      @(posedge clk);
      {cmd_valid, ras_n, cas_n, we_n} <= 4'h7;
      {bg, ba, a17, a} <= ~{w[21:17], w[13:0]};
   endtask : mrs
endmodule : wpm_ctl_model

// ---- tb/tb_top.sv ----
// Bench for the write-path mode register block, fed by the controller model.
// Assumes outputs settle within three clocks of a command.
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_top;
   logic mclk = 1'h0, rst_n = 1'h0, wr_act = 1'h0, pre2 = 1'h0;
   logic cv, ras, cas, we, a17;
   logic [1:0] bg, ba;
   logic [13:0] a;
   logic [4:0] rl = 5'h10;
   logic [2:0] pl = 3'h2;
   logic [4:0] cwl_tab [8] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h12, 5'h14};
   logic [21:0] v;
   int n_fail = 0, total_checks = 0;
   always #4 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////
   wpm_ctl_model ctl_u (.clk(mclk), .cmd_valid(cv), .ras_n(ras), .cas_n(cas),
      .we_n(we), .bg(bg), .ba(ba), .a17(a17), .a(a));
   wpm_mode_regs dut_u (.MCLK(mclk), .RST_N(rst_n), .CMD_VALID(cv), .RAS_N(ras),
      .CAS_N(cas), .WE_N(we), .BG(bg), .BA(ba), .A17(a17), .A(a),
      .WRITE_ACTIVE(wr_act), .TWO_CLK_PREAMBLE(pre2), .READ_LATENCY(rl),
      .PARITY_DELAY(pl), .OUTPUT_DISABLE(), .EXTRA_TERMINATION_STROBE(),
      .WRITE_BYTE_MASK_ALLOWED(), .BUS_INVERSION_ALLOWED(), .WRITE_CRC_EN(),
      .WRITE_TIME_TERMINATION(), .SELFREFRESH_TEMP_RANGE(),
      .AUTOMATIC_RANGE_SWITCHING(), .COLUMN_WRITE_DELAY(), .CWL_CODE_INVALID(),
      .WRITE_LEVELING(), .TERM_SELECT(), .TOTAL_WRITE_DELAY(), .RESERVED_ERROR());
   ////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   // Fixed wait: the latency sum and termination select are the slowest outputs, one clock after a command
   task automatic put(input logic [2:0] sel, input logic [21:0] w);
      w[20:18] = sel;
      ctl_u.mrs(w);
      repeat (3) @(posedge mclk);
      #1;
   endtask : put
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (9) @(posedge mclk);
      #1;
      `CHK("ts", 3'h1, dut_u.TERM_SELECT)
      @(posedge mclk);
      rst_n <= 1'h1;
      repeat (2) @(posedge mclk);
      #1;
      `CHK("ts", 3'h2, dut_u.TERM_SELECT)
      `CHK("od", 1'h0, dut_u.OUTPUT_DISABLE)
      `CHK("cwl", 5'h09, dut_u.COLUMN_WRITE_DELAY)
      `CHK("wl", 6'h0B, dut_u.TOTAL_WRITE_DELAY)
      $display("end reset");
      put(wpm_pkg::SEL_MR1, 22'h00_0008);
      @(posedge mclk);
      wr_act <= 1'h1;
      // Two-clock preamble is never on here, so the codes for 9 to 12 are fair
      for (int i = 0; i < 8; i++) begin
         v = {9'h000, i[0], (i < 5) ? i[2:0] : 3'h0, 1'h0, i[1:0], i[2:0], 3'h0};
         put(wpm_pkg::SEL_MR2, v);
         `CHK("crc", i[0], dut_u.WRITE_CRC_EN)
         `CHK("wtt", v[11:9], dut_u.WRITE_TIME_TERMINATION)
         `CHK("srt", i[1:0], dut_u.SELFREFRESH_TEMP_RANGE)
         `CHK("asr", i[1:0] == 2'h3, dut_u.AUTOMATIC_RANGE_SWITCHING)
         `CHK("cwl", cwl_tab[i], dut_u.COLUMN_WRITE_DELAY)
         `CHK("wl", 6'(rl - 5'h01) + 6'(pl) + 6'(cwl_tab[i]), dut_u.TOTAL_WRITE_DELAY)
         `CHK("ts", (v[11:9] != 3'h0) ? 3'h4 : 3'h2, dut_u.TERM_SELECT)
      end
      $display("end fields");
      put(wpm_pkg::SEL_MR1, 22'h00_1888);
      `CHK("od", 1'h1, dut_u.OUTPUT_DISABLE)
      `CHK("xts", 1'h1, dut_u.EXTRA_TERMINATION_STROBE)
      `CHK("msk", 1'h0, dut_u.WRITE_BYTE_MASK_ALLOWED)
      `CHK("inv", 1'h0, dut_u.BUS_INVERSION_ALLOWED)
      `CHK("lvl", 1'h1, dut_u.WRITE_LEVELING)
      put(wpm_pkg::SEL_MR2, 22'h00_0200);
      `CHK("wtt", 3'h0, dut_u.WRITE_TIME_TERMINATION)
      `CHK("ts", 3'h2, dut_u.TERM_SELECT)
      put(wpm_pkg::SEL_MR1, 22'h00_0008);
      `CHK("od", 1'h0, dut_u.OUTPUT_DISABLE)
      `CHK("msk", 1'h1, dut_u.WRITE_BYTE_MASK_ALLOWED)
      `CHK("inv", 1'h1, dut_u.BUS_INVERSION_ALLOWED)
      `CHK("ts", 3'h4, dut_u.TERM_SELECT)
      $display("end mr1");
      put(3'h3, 22'h00_1E00);
      put(wpm_pkg::SEL_UNUSED, 22'h00_1E00);
      `CHK("wtt", 3'h1, dut_u.WRITE_TIME_TERMINATION)
      `CHK("crc", 1'h0, dut_u.WRITE_CRC_EN)
      put(wpm_pkg::SEL_MR2, 22'h20_0000);
      `CHK("rsv", 1'h1, dut_u.RESERVED_ERROR)
      $display("end select");
      @(posedge mclk);
      pre2 <= 1'h1;
      put(wpm_pkg::SEL_MR2, 22'h00_0018);
      `CHK("bad", 1'h1, dut_u.CWL_CODE_INVALID)
      `CHK("rsv", 1'h0, dut_u.RESERVED_ERROR)
      put(wpm_pkg::SEL_MR2, 22'h00_0020);
      `CHK("bad", 1'h0, dut_u.CWL_CODE_INVALID)
      `CHK("cwl", 5'h0E, dut_u.COLUMN_WRITE_DELAY)
      $display("end preamble");
      put(wpm_pkg::SEL_MR1, 22'h00_0010);
      `CHK("wl", 6'h0E + 6'(rl - 5'h02) + 6'(pl), dut_u.TOTAL_WRITE_DELAY)
      @(posedge mclk);
      rl <= 5'h12;
      pl <= 3'h1;
      repeat (3) @(posedge mclk);
      #1;
      `CHK("wl", 6'h1F, dut_u.TOTAL_WRITE_DELAY)
      put(wpm_pkg::SEL_MR1, 22'h00_0018);
      `CHK("wl", 6'h0F, dut_u.TOTAL_WRITE_DELAY)
      $display("end latency");
      report_and_stop();
   end
endmodule : tb_top
